//--- verilog/sep_eeprom.sv
// Purpose: two-wire serial eeprom slave, 8K bytes, page write
// Assumes: scl and sda sampled in clk_sys; no separate bus reset
// Notes: page latches copied to the array during the program cycle
//
// Overview of operation
// [RULE1] two address bytes per access, high byte first
// [RULE2] high byte bits 12..8 pick block, top three ignored
// [RULE3] write select acked, then two address bytes expected
// [RULE4] write inhibit high from start to address blocks data
// [RULE5] byte write: one data byte acked, then stop
// [RULE6] page write up to 32 bytes within one row
// [RULE7] write increments only five low address bits
// [RULE8] program only on stop right after an ack slot
// [RULE9] inputs ignored while programming runs
// [RULE10] select not acked while busy, acked afterwards
// [RULE11] master may poll with start and select
// [RULE12] delivered memory reads all ones
// [RULE13] thirteen-bit counter increments after each read byte
// [RULE14] current read: ack, output byte, count up
// [RULE15] random read uses dummy write then read select
// [RULE16] acked read bytes stream next consecutive byte
// [RULE17] read past top address wraps to zero
// [RULE18] no ack on ninth bit ends read to standby
// [RULE19] master repeats same select bits in random read
// [RULE20] select: type code, three chip selects, rw bit
// [RULE21] receiver pulls sda low on ninth clock
// [RULE22] respond only when type and chip selects match
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic reset_n, // async reset, low active
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // sda drive value, always low
  output logic sda_oe_n, // low while sda pulled low
  input wire logic [2:0] chip_select_pins, // address straps
  input wire logic write_inhibit_pin, // high blocks writes
  output logic busy // program cycle running
);
  import sep_pkg::*;

  typedef struct packed {
    sep_state_t state;
    logic [3:0] bitcnt;
    logic bit_seen;
    logic [7:0] shift;
    logic [ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic drive_low;
    logic inhibit;
    logic acked_last;
    logic [ROW_LSB_W:0] nbytes;
    logic [ROW_BYTES-1:0] dirty;
    logic programming;
    logic [23:0] timer;
    logic [ROW_LSB_W:0] copy_idx;
    logic [1:0] wi_s;
    logic [2:0] cs_s0;
    logic [2:0] cs_s1;
  } sep_st_t;

  sep_st_t st_r;
  sep_st_t st_nxt;
  sep_bus_ev_t ev;
  sep_mem_req_t mreq;
  logic [7:0] mem_rdata;
  logic [7:0] page [ROW_BYTES];
  logic page_we;
  logic [ROW_LSB_W-1:0] page_idx;
  logic [7:0] rx_byte;
  logic sel_match;
  logic write_block;
  logic in_frame;
  logic bit_rise;
  logic bit_fall;
  logic ack_slot;
  logic last_data_bit;
  logic stop_in_slot;
  logic copy_run;
  logic [ROW_LSB_W-1:0] copy_col;
  logic [ADDR_W-1:0] copy_addr;

  localparam logic [23:0] WRITE_LEN = 24'(WRITE_CYCLES);

  sep_bus_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .bus_ev(ev)
  );

  sep_mem u_mem (
    .clk_sys(clk_sys),
    .req(mreq),
    .rdata(mem_rdata)
  );

  // page latches collect data until the program cycle
  always_ff @(posedge clk_sys) begin
    if (page_we) begin
      page[page_idx] <= rx_byte;
    end
  end

  assign rx_byte = st_r.shift;
  assign write_block = st_r.inhibit | st_r.wi_s[1];
  // [RULE22] select match
  assign sel_match = (st_r.shift[7:SELECT_TYPE_LSB] == TYPE_CODE) &&
    (st_r.shift[SELECT_TYPE_LSB-1:SELECT_CS_LSB] == st_r.cs_s1);

  // idle and ignore wait for the next start, scl edges do nothing there
  assign in_frame = (st_r.state != SEP_IDLE) &&
    (st_r.state != SEP_IGNORE);
  assign bit_rise = ev.rise & in_frame;
  // the scl fall that closes a start carries no bit: it would miscount
  assign bit_fall = ev.fall & in_frame & st_r.bit_seen;
  assign ack_slot = (st_r.bitcnt == ACK_SLOT);
  assign last_data_bit = (st_r.bitcnt == BYTE_BITS - 4'h1);
  // [RULE5] byte or page write ends with a stop after the ack
  assign stop_in_slot = (st_r.state == SEP_WDATA) &&
    (st_r.bitcnt == 4'h0) && st_r.acked_last && (st_r.nbytes != '0);
  // copy index runs 0..32, its top bit marks the copy as done
  assign copy_col = st_r.copy_idx[ROW_LSB_W-1:0];
  assign copy_run = ~st_r.copy_idx[ROW_LSB_W];
  assign copy_addr = {st_r.addr[ADDR_W-1:ROW_LSB_W], copy_col};

  always_comb begin
    st_nxt = st_r;
    page_we = 1'b0;
    page_idx = st_r.addr[ROW_LSB_W-1:0];
    mreq.we = 1'b0;
    mreq.addr = st_r.addr;
    mreq.wdata = 8'h00;
    st_nxt.wi_s = {st_r.wi_s[0], write_inhibit_pin};
    st_nxt.cs_s0 = chip_select_pins;
    st_nxt.cs_s1 = st_r.cs_s0;

    if (st_r.programming) begin
      // [RULE9] bus ignored while busy
      st_nxt.state = SEP_IDLE;
      st_nxt.drive_low = 1'b0;
      // dirty latches of the row go to the array, one per clock
      if (copy_run) begin
        page_idx = copy_col;
        mreq.addr = copy_addr;
        mreq.wdata = page[copy_col];
        mreq.we = st_r.dirty[copy_col];
        st_nxt.copy_idx = st_r.copy_idx + 1'b1;
      end
      st_nxt.timer = st_r.timer + 1'b1;
      if (st_r.timer == WRITE_LEN - 24'h1) begin
        st_nxt.programming = 1'b0;
        st_nxt.dirty = '0;
      end
    end else if (ev.start) begin
      // [RULE11] repeated start re-enters select
      st_nxt.state = SEP_SELECT;
      st_nxt.bitcnt = 4'h0;
      st_nxt.bit_seen = 1'b0;
      st_nxt.drive_low = 1'b0;
      // [RULE4] inhibit sampled from start on
      st_nxt.inhibit = st_r.wi_s[1];
      st_nxt.nbytes = '0;
    end else if (ev.stop) begin
      // [RULE8] stop counts only in the slot after an ack
      if (stop_in_slot) begin
        st_nxt.programming = 1'b1;
        st_nxt.timer = 24'h0;
        st_nxt.copy_idx = '0;
      end
      st_nxt.state = SEP_IDLE;
      st_nxt.drive_low = 1'b0;
    end else if (bit_rise) begin
      st_nxt.bit_seen = 1'b1;
      if (ack_slot) begin
        // [RULE18] master nack ends read
        if (st_r.state == SEP_RDATA && ev.sda) begin
          st_nxt.state = SEP_IDLE;
        end
      end else begin
        st_nxt.shift = {st_r.shift[6:0], ev.sda};
      end
      if (st_r.state == SEP_ADDR_HI || st_r.state == SEP_ADDR_LO) begin
        st_nxt.inhibit = st_r.inhibit | st_r.wi_s[1];
      end
    end else if (bit_fall) begin
      st_nxt.bit_seen = 1'b0;
      st_nxt.drive_low = 1'b0;
      if (last_data_bit) begin
        // eighth bit just finished: decide on ack
        st_nxt.bitcnt = ACK_SLOT;
        unique case (st_r.state)
          SEP_SELECT: begin
            if (sel_match) begin
              // [RULE10] ack select when idle
              st_nxt.drive_low = 1'b1;
            end else begin
              st_nxt.state = SEP_IGNORE;
            end
          end
          // [RULE3] address bytes acked
          SEP_ADDR_HI: st_nxt.drive_low = 1'b1;
          SEP_ADDR_LO: st_nxt.drive_low = 1'b1;
          SEP_WDATA: begin
            // [RULE4] inhibited data not acked
            st_nxt.drive_low = ~write_block;
            st_nxt.inhibit = write_block;
          end
          SEP_RDATA: st_nxt.drive_low = 1'b0;
          default: st_nxt.state = SEP_IGNORE;
        endcase
      end else if (ack_slot) begin
        st_nxt.bitcnt = 4'h0;
        unique case (st_r.state)
          SEP_SELECT: begin
            // [RULE20] rw bit picks direction
            if (st_r.shift[SELECT_RW_BIT]) begin
              // [RULE15] read select after dummy write
              st_nxt.state = SEP_RDATA;
              st_nxt.tx = mem_rdata;
              // [RULE13] count up after each read byte
              st_nxt.addr = st_r.addr + 1'b1;
              st_nxt.drive_low = ~mem_rdata[7];
            end else begin
              st_nxt.state = SEP_ADDR_HI;
            end
          end
          SEP_ADDR_HI: begin
            // [RULE1] high byte first; [RULE2] top bits ignored
            st_nxt.addr[BLOCK_MSB:8] = st_r.shift[4:0];
            st_nxt.state = SEP_ADDR_LO;
          end
          SEP_ADDR_LO: begin
            st_nxt.addr[7:0] = st_r.shift;
            st_nxt.state = SEP_WDATA;
            st_nxt.acked_last = 1'b0;
          end
          SEP_WDATA: begin
            st_nxt.acked_last = ~st_r.inhibit;
            if (!st_r.inhibit) begin
              // [RULE6] latch byte in current row
              page_we = 1'b1;
              st_nxt.dirty[st_r.addr[ROW_LSB_W-1:0]] = 1'b1;
              if (st_r.nbytes != (ROW_LSB_W+1)'(ROW_BYTES)) begin
                st_nxt.nbytes = st_r.nbytes + 1'b1;
              end
              // [RULE7] row-local increment
              st_nxt.addr[ROW_LSB_W-1:0] =
                st_r.addr[ROW_LSB_W-1:0] + 1'b1;
            end
          end
          SEP_RDATA: begin
            // [RULE16] next byte after master ack
            // [RULE17] counter wraps naturally at top
            st_nxt.tx = mem_rdata;
            st_nxt.addr = st_r.addr + 1'b1;
            st_nxt.drive_low = ~mem_rdata[7];
          end
          default: st_nxt.state = SEP_IGNORE;
        endcase
      end else begin
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        if (st_r.state == SEP_RDATA) begin
          // [RULE14] shift out msb first
          st_nxt.tx = {st_r.tx[6:0], 1'b1};
          st_nxt.drive_low = ~st_r.tx[6];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{state: SEP_IDLE, tx: 8'hff, wi_s: 2'h0, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // [RULE21] open-drain ack and data drive
  assign sda_out = 1'b0;
  assign sda_oe_n = ~st_r.drive_low;
  assign busy = st_r.programming;
endmodule : sep_eeprom
`default_nettype wire

//--- verilog/sep_pkg.sv
// Purpose: shared constants and types of the serial eeprom slave
// Assumes: 25 MHz system clock, 8K x 8 memory array
// Notes: timing counts derived from printed times
package sep_pkg;
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned MEM_DEPTH = 8192;
  localparam int unsigned ROW_BYTES = 32;
  localparam int unsigned ROW_LSB_W = 5;
  localparam int unsigned BLOCK_MSB = 12;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam int unsigned SELECT_RW_BIT = 0;
  localparam int unsigned SELECT_CS_LSB = 1;
  localparam int unsigned SELECT_TYPE_LSB = 4;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // 1 ms program cycle, inside the 10 ms limit; keeps polling short
  localparam int unsigned WRITE_TIME_US = 1000;
  localparam int unsigned WRITE_CYCLES =
    (WRITE_TIME_US / 1000) * (SYS_CLK_HZ / 1000);

  typedef enum logic [6:0] {
    SEP_IDLE = 7'h01,
    SEP_SELECT = 7'h02,
    SEP_ADDR_HI = 7'h04,
    SEP_ADDR_LO = 7'h08,
    SEP_WDATA = 7'h10,
    SEP_RDATA = 7'h20,
    SEP_IGNORE = 7'h40
  } sep_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } sep_bus_ev_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sep_mem_req_t;
endpackage : sep_pkg

//--- verilog/sep_bus_sync.sv
// Purpose: brings scl/sda into clk_sys and decodes bus conditions
// Assumes: pins are asynchronous to clk_sys
// Notes: two-flop synchroniser, then edge and condition decode
`timescale 1ns/1ps
`default_nettype none
module sep_bus_sync (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, low active
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output sep_pkg::sep_bus_ev_t bus_ev // decoded events
);
  import sep_pkg::*;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
  } sep_sync_st_t;

  sep_sync_st_t st_r;
  sep_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_s = {st_r.scl_s[0], scl_in};
    st_nxt.sda_s = {st_r.sda_s[0], sda_in};
    st_nxt.scl_d = st_r.scl_s[1];
    st_nxt.sda_d = st_r.sda_s[1];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // only the second stage and its delayed copy feed decode
  always_comb begin
    bus_ev.sda = st_r.sda_s[1];
    bus_ev.rise = st_r.scl_s[1] & ~st_r.scl_d;
    bus_ev.fall = ~st_r.scl_s[1] & st_r.scl_d;
    bus_ev.start = st_r.scl_s[1] & st_r.scl_d & st_r.sda_d &
      ~st_r.sda_s[1];
    bus_ev.stop = st_r.scl_s[1] & st_r.scl_d & ~st_r.sda_d &
      st_r.sda_s[1];
  end
endmodule : sep_bus_sync
`default_nettype wire

//--- verilog/sep_mem.sv
// Purpose: 8K byte storage array of the eeprom
// Assumes: one read every clock, plus one write when req.we is set, at the same address
// Notes: delivered content is all ones
`timescale 1ns/1ps
`default_nettype none
module sep_mem (
  input wire logic clk_sys, // system clock
  input wire sep_pkg::sep_mem_req_t req, // write request / address
  output logic [7:0] rdata // registered read data
);
  import sep_pkg::*;

  logic [7:0] cells [MEM_DEPTH];

  // [RULE12] erased content
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      cells[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (req.we) begin
      cells[req.addr] <= req.wdata;
    end
    rdata <= cells[req.addr];
  end
endmodule : sep_mem
`default_nettype wire

//--- test/sep_eeprom_assertions.sv
// Purpose: pin-level checks of the eeprom slave
// Assumes: one clk_sys domain, scl and sda oversampled
// Notes: attached to every sep_eeprom by bind
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_chk (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, low active
  input wire logic scl_in, // bus clock
  input wire logic sda_in, // bus data level
  input wire logic sda_out, // drive value
  input wire logic sda_oe_n, // low while pulling sda
  input wire logic [2:0] chip_select_pins, // straps
  input wire logic write_inhibit_pin, // write block
  input wire logic busy // program cycle
);
  import sep_pkg::*;
  logic [31:0] busy_cnt_r;
  // counts program cycle length, too long for a repetition
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence held_low_s;
    !sda_oe_n [*4];
  endsequence
  sequence stop_seen_s;
    scl_in && sda_in && sda_oe_n;
  endsequence
  out_low_a: assert property (sda_out == 1'b0)
    else $error("sda drive value not low");
  oe_scl_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda drive changed while scl high");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> held_low_s)
    else $error("sda low not held");
  busy_quiet_a: assert property (busy |-> sda_oe_n)
    else $error("sda driven while programming");
  busy_stop_a: assert property ($rose(busy) |-> stop_seen_s)
    else $error("program started without stop");
  busy_len_a: assert property ($fell(busy) |-> busy_cnt_r == WRITE_CYCLES)
    else $error("program cycle length wrong");
  busy_max_a: assert property (busy_cnt_r <= WRITE_CYCLES)
    else $error("program cycle too long");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("program cycle dropped early");
endmodule : sep_eeprom_chk
bind sep_eeprom sep_eeprom_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .chip_select_pins(chip_select_pins),
  .write_inhibit_pin(write_inhibit_pin), .busy(busy));
`default_nettype wire

//--- test/sep_master_model.sv
// Purpose: bus master driving scl and sda of the eeprom
// Assumes: link_clk of 6 ns, quarter bit of 40 ticks
// Notes: scl stands high between frames
`timescale 1ns/1ps
`default_nettype none
module sep_master_model (
  input wire logic link_clk, // timing clock
  input wire logic sda, // resolved data wire
  output logic scl, // bus clock drive
  output logic sda_low // pulls data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (40) @(posedge link_clk);
  endtask : q
  // data moves only while scl low
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask : bit_x
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  // stop right after the ack slot
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask : stop
  // msb first, released for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, r);
      b = {b[6:0], r};
    end
    bit_x(!mack, r);
  endtask : rbyte
endmodule : sep_master_model
`default_nettype wire

//--- test/tb_sep_eeprom.sv
// Purpose: self-checking bench of the eeprom slave
// Assumes: chip straps fixed at 3'h5
// Notes: one real program cycle, about 1 ms
`timescale 1ns/1ps
`default_nettype none
module tb_sep_eeprom;
  import sep_pkg::*;
  localparam logic [2:0] CS = 3'h5;
  logic clk_sys = 1'b0, link_clk = 1'b0, reset_n = 1'b0, wi = 1'b0;
  logic [2:0] cs_pins = CS;
  int miscompares = 0, cmp_count = 0;
  wire logic scl, sda_low, sda_oe_n, busy, sda_out;
  // pull-up wire: low if either party pulls
  wire logic sda = !(sda_low || !sda_oe_n);
  always #20 clk_sys = ~clk_sys;
  initial begin
    #1.1;
    forever #3 link_clk = ~link_clk;
  end
  sep_master_model mst (.link_clk(link_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  sep_eeprom dut (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_select_pins(cs_pins), .write_inhibit_pin(wi), .busy(busy));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic sel(input logic rw, input logic exp);
    logic a;
    mst.start();
    mst.wbyte({TYPE_CODE, CS, rw}, a);
    chk("sel_ack", {7'h0, exp}, {7'h0, a});
  endtask : sel
  task automatic point(input logic [15:0] ad);
    logic a;
    sel(1'b0, 1'b1);
    mst.wbyte(ad[15:8], a);
    chk("hi_ack", 8'h1, {7'h0, a});
    mst.wbyte(ad[7:0], a);
    chk("lo_ack", 8'h1, {7'h0, a});
  endtask : point
  task automatic rnd_rd(input logic [15:0] ad, input int n,
    input logic [7:0] e [3]);
    logic [7:0] d;
    point(ad);
    sel(1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i < n - 1, d);
      chk("rd_byte", e[i], d);
    end
    mst.stop();
  endtask : rnd_rd
  task automatic t_bad_sel();
    logic a;
    mst.start();
    mst.wbyte({TYPE_CODE, ~CS, 1'b0}, a);
    chk("cs_nack", 8'h0, {7'h0, a});
    mst.start();
    mst.wbyte({4'h5, CS, 1'b0}, a);
    chk("type_nack", 8'h0, {7'h0, a});
    mst.stop();
  endtask : t_bad_sel
  task automatic t_inhibit();
    logic a;
    @(posedge clk_sys);
    wi <= 1'b1;
    point(16'h0040);
    mst.wbyte(8'h3c, a);
    chk("wi_nack", 8'h0, {7'h0, a});
    mst.stop();
    repeat (10) @(posedge clk_sys);
    chk("wi_busy", 8'h0, {7'h0, busy});
    wi <= 1'b0;
  endtask : t_inhibit
  task automatic t_page();
    logic a;
    point(16'hfffe);
    for (int i = 0; i < 3; i++) begin
      mst.wbyte(8'ha0 + 8'(i), a);
      chk("wr_ack", 8'h1, {7'h0, a});
    end
    mst.stop();
    repeat (10) @(posedge clk_sys);
    chk("busy_on", 8'h1, {7'h0, busy});
    sel(1'b0, 1'b0);
    mst.stop();
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge clk_sys);
    chk("busy_off", 8'h0, {7'h0, busy});
    sel(1'b0, 1'b1);
    mst.stop();
  endtask : t_page
  task automatic t_read();
    logic [7:0] d;
    rnd_rd(16'h1ffe, 1, '{8'ha0, 8'h0, 8'h0});
    sel(1'b1, 1'b1);
    mst.rbyte(1'b0, d);
    chk("cur_rd", 8'ha1, d);
    mst.stop();
    rnd_rd(16'h1fff, 3, '{8'ha1, ERASED_BYTE, ERASED_BYTE});
    rnd_rd(16'h1fe0, 1, '{8'ha2, 8'h0, 8'h0});
    rnd_rd(16'h0040, 1, '{ERASED_BYTE, 8'h0, 8'h0});
  endtask : t_read
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_bad_sel();
    t_inhibit();
    t_page();
    t_read();
    end_sim();
  end
  initial begin
    // all scenarios take about 35000 clocks, the program cycle most
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    end_sim();
  end
endmodule : tb_sep_eeprom
`default_nettype wire
